// *** src/ldsl_shift_latch.v ***
// serial shift register and control data latch of a 9-channel led driver
`include "ldsl_regs.vh"
module ldsl_shift_latch
#(
  parameter GAP_W = `LDSL_GAP_W
)
(
  input  wire                      clk_sys,
  input  wire                      rstn,
  input  wire                      serial_shift_clock_in,
  input  wire                      serial_data_in,
  output reg                       serial_data_out,
  output reg  [`LDSL_GS_W-1:0]     red0_level,
  output reg  [`LDSL_GS_W-1:0]     green0_level,
  output reg  [`LDSL_GS_W-1:0]     blue0_level,
  output reg  [`LDSL_GS_W-1:0]     red1_level,
  output reg  [`LDSL_GS_W-1:0]     green1_level,
  output reg  [`LDSL_GS_W-1:0]     blue1_level,
  output reg  [`LDSL_GS_W-1:0]     red2_level,
  output reg  [`LDSL_GS_W-1:0]     green2_level,
  output reg  [`LDSL_GS_W-1:0]     blue2_level,
  output reg  [`LDSL_BRT_W-1:0]    red_group_brightness,
  output reg  [`LDSL_BRT_W-1:0]    green_group_brightness,
  output reg  [`LDSL_BRT_W-1:0]    blue_group_brightness,
  output reg                       outputs_blank,
  output reg                       display_repeat,
  output reg                       latch_timing_restart,
  output reg                       ext_ref_clock_sel,
  output reg                       rising_edge_sel,
  output reg                       pwm_restart,
  output reg                       latch_pulse
);

  // ********************************************************
  // input synchronisers
  // ********************************************************
  reg [2:0] sck_sync_ff;
  reg [2:0] sdi_sync_ff;
  reg       sck_state_ff;

  // three stages; a change counts once stages two and three agree
  // clock and data share one depth, so the data bit seen with a detected
  // rise is the one the controller set up before that rise
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sck_sync_ff  <= 3'h0;
      sdi_sync_ff  <= 3'h0;
      sck_state_ff <= 1'b0;
    end
    else
    begin
      sck_sync_ff <= {sck_sync_ff[1:0], serial_shift_clock_in};
      sdi_sync_ff <= {sdi_sync_ff[1:0], serial_data_in};
      if (sck_sync_ff[1] == sck_sync_ff[2])
        sck_state_ff <= sck_sync_ff[2];
    end
  end

  wire sck_rise = (sck_sync_ff[1] == sck_sync_ff[2]) && sck_sync_ff[2] && !sck_state_ff;
  // data sampled alongside the agreed clock edge, delayed equally
  wire sdi_bit  = sdi_sync_ff[2];

  // ********************************************************
  // shift register
  // ********************************************************
  // no reset: contents are undefined until shifted in
  // leaving it unreset also keeps 224 flops out of the reset tree
  reg [`LDSL_SHIFT_W-1:0] shift_ff;

  always @(posedge clk_sys)
  begin
    if (sck_rise)
      shift_ff <= {shift_ff[`LDSL_SHIFT_W-2:0], sdi_bit};
  end

  // msb follows the shift register with one register stage
  // the extra stage keeps the pin glitch free at the cost of one cycle
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      serial_data_out <= 1'b0;
    else
      serial_data_out <= shift_ff[`LDSL_SHIFT_W-1];
  end

  // command decode; only a write command may ever move the latch
  wire cmd_ok = (shift_ff[`LDSL_SHIFT_W-1 -: `LDSL_CMD_W] == `LDSL_CMD_WRITE);

  // ********************************************************
  // idle timer for the internal latch pulse
  // ********************************************************
  // measures the interval between the last two rises and fires when the
  // clock has been idle for eight of them; the saturating gap counter and
  // the armed flag keep a stopped clock from wrapping and firing twice
  // the counter width bounds the slowest link clock that can still latch
  reg [GAP_W-1:0] gap_cnt_ff;
  reg [GAP_W-1:0] last_gap_ff;
  reg [1:0]       rise_seen_ff;
  reg             armed_ff;

  wire [GAP_W+2:0] idle_limit = {last_gap_ff, 3'h0};
  wire             gap_max    = &gap_cnt_ff;
  wire             fire       = armed_ff && rise_seen_ff[1] && !sck_rise
                                && ({3'h0, gap_cnt_ff} >= idle_limit) && cmd_ok;

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      gap_cnt_ff   <= {GAP_W{1'b0}};
      last_gap_ff  <= {GAP_W{1'b0}};
      rise_seen_ff <= 2'h0;
      armed_ff     <= 1'b0;
      latch_pulse  <= 1'b0;
    end
    else
    begin
      latch_pulse <= fire;
      if (sck_rise)
      begin
        last_gap_ff  <= gap_cnt_ff;
        gap_cnt_ff   <= {{(GAP_W-1){1'b0}}, 1'b1};
        rise_seen_ff <= {rise_seen_ff[0], 1'b1};
        armed_ff     <= 1'b1;
      end
      else
      begin
        if (!gap_max)
          gap_cnt_ff <= gap_cnt_ff + {{(GAP_W-1){1'b0}}, 1'b1};
        // one pulse per burst of clocks
        if (fire || gap_max)
          armed_ff <= 1'b0;
      end
    end
  end

  // ********************************************************
  // control data latch
  // ********************************************************
  // only the blank bit has a reset value; the rest are undefined
  // bit 213 of latch_ff stays unread: blank_ff carries it with its reset
  reg [`LDSL_LATCH_W-1:0] latch_ff;
  reg                     blank_ff;

  always @(posedge clk_sys)
  begin
    if (fire)
      latch_ff <= shift_ff[`LDSL_LATCH_W-1:0];
  end

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      blank_ff <= 1'b1;
    else if (fire)
      blank_ff <= shift_ff[`LDSL_BLANK_BIT];
  end

  // ********************************************************
  // settings outputs, taken from the latch; pwm restart also reads the shift register
  // ********************************************************
  // registered copy so that every field changes on the same edge
  // the cost is one cycle of latency after the latch pulse
  always @(posedge clk_sys)
  begin
    red0_level             <= latch_ff[`LDSL_RED0_LSB +: `LDSL_GS_W];
    green0_level           <= latch_ff[`LDSL_GREEN0_LSB +: `LDSL_GS_W];
    blue0_level            <= latch_ff[`LDSL_BLUE0_LSB +: `LDSL_GS_W];
    red1_level             <= latch_ff[`LDSL_RED1_LSB +: `LDSL_GS_W];
    green1_level           <= latch_ff[`LDSL_GREEN1_LSB +: `LDSL_GS_W];
    blue1_level            <= latch_ff[`LDSL_BLUE1_LSB +: `LDSL_GS_W];
    red2_level             <= latch_ff[`LDSL_RED2_LSB +: `LDSL_GS_W];
    green2_level           <= latch_ff[`LDSL_GREEN2_LSB +: `LDSL_GS_W];
    blue2_level            <= latch_ff[`LDSL_BLUE2_LSB +: `LDSL_GS_W];
    red_group_brightness   <= latch_ff[`LDSL_BRT_RED_LSB +: `LDSL_BRT_W];
    green_group_brightness <= latch_ff[`LDSL_BRT_GREEN_LSB +: `LDSL_BRT_W];
    blue_group_brightness  <= latch_ff[`LDSL_BRT_BLUE_LSB +: `LDSL_BRT_W];
    display_repeat         <= latch_ff[`LDSL_DSPRPT_BIT];
    latch_timing_restart   <= latch_ff[`LDSL_RESTART_BIT];
    ext_ref_clock_sel      <= latch_ff[`LDSL_EXTCLK_BIT];
    rising_edge_sel        <= latch_ff[`LDSL_EDGE_BIT];
  end

  // blank and the pwm restart request have defined reset values
  // the restart pulse reads the restart bit being latched, not the old one
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      outputs_blank <= 1'b1;
      pwm_restart   <= 1'b1;
    end
    else
    begin
      outputs_blank <= blank_ff;
      // held while blank; one pulse per latch when restart bit set
      pwm_restart   <= blank_ff || (fire && shift_ff[`LDSL_RESTART_BIT]);
    end
  end

endmodule

// *** src/ldsl_regs.vh ***
// constants for the led driver serial shift and latch block
`ifndef LDSL_REGS_VH
`define LDSL_REGS_VH
`define LDSL_SHIFT_W       224
`define LDSL_LATCH_W       218
`define LDSL_CMD_W         6
`define LDSL_CMD_WRITE     6'h25
`define LDSL_BLANK_BIT     213
`define LDSL_DSPRPT_BIT    214
`define LDSL_RESTART_BIT   215
`define LDSL_EXTCLK_BIT    216
`define LDSL_EDGE_BIT      217
`define LDSL_GS_W          16
`define LDSL_BRT_W         7
`define LDSL_RED0_LSB      0
`define LDSL_GREEN0_LSB    16
`define LDSL_BLUE0_LSB     32
`define LDSL_RED1_LSB      48
`define LDSL_GREEN1_LSB    64
`define LDSL_BLUE1_LSB     80
`define LDSL_RED2_LSB      96
`define LDSL_GREEN2_LSB    112
`define LDSL_BLUE2_LSB     128
`define LDSL_BRT_RED_LSB   192
`define LDSL_BRT_GREEN_LSB 199
`define LDSL_BRT_BLUE_LSB  206
`define LDSL_IDLE_MULT     8
`define LDSL_GAP_W         24
`endif

// *** tb/ldsl_ctrl_model.sv ***
// controller model that clocks frames into the shift register
module ldsl_ctrl_model (
  output logic sck,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  // the link clock stands low between frames
  initial
  begin
    sck = 1'b0;
    sdi = 1'b0;
  end
  // msb first; data is set while the clock is low and held through the high phase
  task automatic send(input logic [223:0] fr, input int half);
    for (int i = 223; i >= 0; i--)
    begin
      sdi = fr[i];
      #(half) sck = 1'b1;
      #(half) sck = 1'b0;
    end
    sdi = ~sdi; // a released line must not keep showing the last bit
  endtask
endmodule

// *** tb/ldsl_props.sv ***
// concurrent checks on the ports of the shift and latch block
module ldsl_props (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        serial_shift_clock_in,
  input wire logic        serial_data_out,
  input wire logic [15:0] red0_level,
  input wire logic [15:0] blue2_level,
  input wire logic [6:0]  red_group_brightness,
  input wire logic        outputs_blank,
  input wire logic        latch_timing_restart,
  input wire logic        pwm_restart,
  input wire logic        latch_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // settings move only in the cycle after a pulse; case equality as they start unknown
  AST_HOLD: assert property (!latch_pulse |=>
    {red0_level, blue2_level, outputs_blank} === $past({red0_level, blue2_level, outputs_blank}))
    else $error("settings moved");
  AST_BRT_HOLD: assert property (!latch_pulse |=>
    red_group_brightness === $past(red_group_brightness)) else $error("brightness moved");
  AST_RST: assert property ($rose(rstn) |->
    outputs_blank && pwm_restart && !latch_pulse) else $error("bad state after reset");
  AST_PULSE_ONE: assert property (latch_pulse |=> !latch_pulse)
    else $error("latch pulse too long");
  AST_PULSE_IDLE: assert property ($changed(serial_shift_clock_in) |=>
    !latch_pulse [*8]) else $error("latch while clock active");
  AST_SDO_IDLE: assert property ($stable(serial_shift_clock_in) [*8] |->
    $stable(serial_data_out)) else $error("serial out moved without clock");
  AST_BLANK_RESTART: assert property (outputs_blank |-> pwm_restart)
    else $error("blank without pwm restart");
  // the newly latched restart bit shows one cycle after the pulse that carried the restart
  AST_RESTART_PULSE: assert property (latch_pulse ##1 latch_timing_restart |->
    $past(pwm_restart)) else $error("no restart on latch");
  AST_RESTART_IDLE: assert property (!outputs_blank && !latch_pulse
    && !$past(latch_pulse) |-> !pwm_restart) else $error("stray pwm restart");
  C_LATCH: cover property (latch_pulse);
  C_RESTART: cover property (latch_pulse && latch_timing_restart);
  C_UNBLANK: cover property ($fell(outputs_blank));
  C_RESTART_ALONE: cover property (latch_pulse && pwm_restart && !outputs_blank);
endmodule
bind ldsl_shift_latch ldsl_props u_props (.clk_sys(clk_sys), .rstn(rstn),
  .serial_shift_clock_in(serial_shift_clock_in), .serial_data_out(serial_data_out),
  .red0_level(red0_level), .blue2_level(blue2_level),
  .red_group_brightness(red_group_brightness), .outputs_blank(outputs_blank),
  .latch_timing_restart(latch_timing_restart), .pwm_restart(pwm_restart),
  .latch_pulse(latch_pulse));

// *** tb/ldsl_shift_latch_tb_top.sv ***
// self-checking bench for the led driver shift and latch block
module ldsl_shift_latch_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rstn;
  logic [223:0] f, lat;
  int bad_count = 0;
  int n_compared = 0;
  wire sck, sdi, sdo, blank, rpt, rse, ext, edg, prs, lp;
  wire [15:0] r0, g0, b0, r1, g1, b1, r2, g2, b2;
  wire [6:0] br, bg, bb;
  ldsl_ctrl_model ctl (.sck(sck), .sdi(sdi));
  // narrow counter width keeps saturation short with the slow link clock
  ldsl_shift_latch #(.GAP_W(12)) uut (.clk_sys(clk_sys), .rstn(rstn),
    .serial_shift_clock_in(sck), .serial_data_in(sdi), .serial_data_out(sdo),
    .red0_level(r0), .green0_level(g0), .blue0_level(b0), .red1_level(r1),
    .green1_level(g1), .blue1_level(b1), .red2_level(r2), .green2_level(g2),
    .blue2_level(b2), .red_group_brightness(br), .green_group_brightness(bg),
    .blue_group_brightness(bb), .outputs_blank(blank), .display_repeat(rpt),
    .latch_timing_restart(rse), .ext_ref_clock_sel(ext), .rising_edge_sel(edg),
    .pwm_restart(prs), .latch_pulse(lp));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset held for 20 cycles; blank, pwm restart and serial out come back defined
  task automatic apply_reset();
    rstn = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 rstn = 1'b1;
    lat[213] = 1'b1;
    chk({sdo, lp, prs, blank}, 4'b0011);
    $display("reset released");
  endtask
  // one frame, then wait for the idle-gap latch and compare against the expected latch
  task automatic burst(input logic [5:0] c, input logic [4:0] fb, input int half);
    int n;
    n = 0;
    for (int i = 0; i < 14; i++)
      f[i*16 +: 16] = 16'(i * 16'h1357 + half);
    f[223:213] = {c, fb};
    ctl.send(f, half);
    chk(sdo, f[223]);
    while (lp !== 1'b1 && n < 2000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(lp, c == 6'h25);
    // the pulse cycle carries the old blank or the restart bit being latched
    chk(prs, lat[213] | ((c == 6'h25) & f[215]));
    if (c == 6'h25)
      lat = f;
    // settings and blank follow the pulse by one cycle
    @(posedge clk_sys);
    #1;
    chk(lp, 1'b0);
    chk(prs, lat[213]);
    chk({b0, g0, r0}, lat[47:0]);
    chk({b1, g1, r1}, lat[95:48]);
    chk({b2, g2, r2}, lat[143:96]);
    chk({bb, bg, br}, lat[212:192]);
    chk({edg, ext, rse, rpt, blank}, lat[217:213]);
    $display("frame %h done after %0d cycles", c, n);
  endtask
  // *******************************
  // main sequence and watchdog
  // *******************************
  initial
  begin
    apply_reset();
    burst(6'h25, 5'b00001, 80);
    burst(6'h05, 5'b00000, 120);
    burst(6'h25, 5'b11110, 400);
    burst(6'h25, 5'b00000, 96);
    burst(6'h25, 5'b00110, 88);
    apply_reset();
    burst(6'h25, 5'b00000, 104);
    stop_test();
  end
  // six frames, two resets and their idle gaps need about 430 us
  initial
  begin
    #600us;
    bad_count++;
    stop_test();
  end
endmodule
